// >>> logic/tx_ctrl_regs.v
// AXI4-Lite register bank for the transmit framer controls of one port
//
// Local design decision: the AXI4-Lite register port.
`include "tx_ctrl_defs.vh"
`default_nettype none

// Contract
// - Inversion field picks none, framing, signaling or payload bits.
// - Jam enable forces bit 8 per channel, bit 7 in T1 signaling frames.
// - In T1 ESF with remote alarm, variant bit selects CI remote alarm.
// - T1 AIS sends all ones when variant bit 0, CI AIS when 1.
// - Code length field selects 5, 6/3, 7 or 16/8/4/2/1 bits.
// - Low watermark field selects 4, 16, 32 or 48 bytes.
// - Interleave kind bit: 0 channel interleave, 1 frame interleave.
// - Interleave enable bit turns interleaved bus off or on.
// - Five-bit select picks channel 1..32 copied to monitor register.
// - BERT direction 0 feeds transmit path, 1 feeds receive serial output.
// - BERT uses framing bit only when framing select is 1.
// - BERT port works only while its enable bit is 1.
// - Each suppress bit excludes one channel bit; bit 7 is channel MSB.
// - E1 synchronizer searches CRC-4 multiframe only when enabled.
// - Synchronizer outputs are gated by its enable bit, except the resync pulse, which fires regardless.
// - T1 loop code enable replaces data with repeating loop code.
// - Auto resync enabled when sync bit is 0, disabled when 1.
// - Rising edge of resync bit starts one resync; software re-arms.
module tx_ctrl_regs (
  input wire aclk,
  input wire aresetn,
  input wire [13:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [13:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire t1_mode,
  input wire esf_mode,
  input wire signaling_frame,
  input wire remote_alarm_send,
  input wire ais_send,
  input wire loop_code_enable,
  input wire [7:0] tx_channel_data,
  input wire [4:0] tx_channel_index,
  input wire tx_channel_strobe,
  output wire invert_framing,
  output wire invert_signaling,
  output wire invert_payload,
  output wire jam_bit8_force,
  output wire jam_bit7_force,
  output wire send_rai_normal,
  output wire send_remote_alarm_ci_variant,
  output wire send_ais_all_ones,
  output wire send_variant_a,
  output wire loop_code_active,
  output wire [4:0] loop_code_bits,
  output wire [5:0] hdlc_low_mark_bytes,
  output wire interleave_active,
  output wire interleave_frame_mode,
  output wire [4:0] monitor_channel_sel,
  output wire bert_to_tx_path,
  output wire bert_to_rx_serial_out,
  output wire bert_in_framing_bit,
  output wire [7:0] bert_bit_use,
  output wire sync_active,
  output wire crc_search_active,
  output wire auto_resync_active,
  output wire resync_start
);

  // ********************
  // Register storage
  // ********************
  reg [7:0] tx_control_four_reg;
  reg [7:0] tx_hdlc_fifo_ctrl_reg;
  reg [7:0] tx_interleave_bus_ctrl_reg;
  reg [7:0] tx_channel_monitor_select_reg;
  reg [7:0] tx_expansion_port_ctrl_reg;
  reg [7:0] tx_bert_bit_suppress_reg;
  reg [7:0] tx_synchronizer_ctrl_reg;
  reg [7:0] channel_monitor_reg;

  // ********************
  // Write channel state
  // ********************
  reg aw_held_reg;
  reg w_held_reg;
  reg [11:0] aw_index_reg;
  reg aw_aligned_reg;
  reg [7:0] w_data_reg;
  reg w_lane0_reg;
  wire aw_take;
  wire w_take;
  wire [11:0] wr_index;
  wire wr_aligned;
  wire [7:0] wr_data;
  wire wr_lane0;
  wire wr_fire;
  reg wr_hit;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  // Address and data may arrive in either order or together
  assign wr_index = aw_held_reg ? aw_index_reg : s_axi_awaddr[13:2];
  assign wr_aligned = aw_held_reg ? aw_aligned_reg : (s_axi_awaddr[1:0] == 2'b00);
  assign wr_data = w_held_reg ? w_data_reg : s_axi_wdata[7:0];
  assign wr_lane0 = w_held_reg ? w_lane0_reg : s_axi_wstrb[0];
  assign wr_fire = (aw_held_reg | aw_take) & (w_held_reg | w_take) & ~s_axi_bvalid;

  always @* begin
    case (wr_index)
      `IDX_TX_CONTROL_FOUR: wr_hit = wr_aligned;
      `IDX_TX_HDLC_FIFO_CTRL: wr_hit = wr_aligned;
      `IDX_TX_INTERLEAVE_BUS_CTRL: wr_hit = wr_aligned;
      `IDX_TX_CHANNEL_MONITOR_SELECT: wr_hit = wr_aligned;
      `IDX_TX_EXPANSION_PORT_CTRL: wr_hit = wr_aligned;
      `IDX_TX_BERT_BIT_SUPPRESS: wr_hit = wr_aligned;
      `IDX_TX_SYNCHRONIZER_CTRL: wr_hit = wr_aligned;
      default: wr_hit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_index_reg <= 12'h000;
      aw_aligned_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_lane0_reg <= 1'b0;
    end else begin
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Unmapped or misaligned writes answer with an error
        s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_held_reg <= 1'b1;
          aw_index_reg <= s_axi_awaddr[13:2];
          aw_aligned_reg <= (s_axi_awaddr[1:0] == 2'b00);
          s_axi_awready <= 1'b0;
        end
        if (w_take) begin
          w_held_reg <= 1'b1;
          w_data_reg <= s_axi_wdata[7:0];
          w_lane0_reg <= s_axi_wstrb[0];
          s_axi_wready <= 1'b0;
        end
        if (s_axi_bvalid & s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
          s_axi_awready <= 1'b1;
          s_axi_wready <= 1'b1;
        end
      end
    end
  end

  // ********************
  // Register writes
  // ********************
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_control_four_reg <= `RST_CTRL_REG;
      tx_hdlc_fifo_ctrl_reg <= `RST_CTRL_REG;
      tx_interleave_bus_ctrl_reg <= `RST_CTRL_REG;
      tx_channel_monitor_select_reg <= `RST_CTRL_REG;
      tx_expansion_port_ctrl_reg <= `RST_CTRL_REG;
      tx_bert_bit_suppress_reg <= `RST_CTRL_REG;
      tx_synchronizer_ctrl_reg <= `RST_CTRL_REG;
    end else if (wr_fire & wr_hit & wr_lane0) begin
      case (wr_index)
        `IDX_TX_CONTROL_FOUR: tx_control_four_reg <= wr_data & `MASK_TX_CONTROL_FOUR;
        `IDX_TX_HDLC_FIFO_CTRL: tx_hdlc_fifo_ctrl_reg <= wr_data & `MASK_TX_HDLC_FIFO_CTRL;
        `IDX_TX_INTERLEAVE_BUS_CTRL: begin
          tx_interleave_bus_ctrl_reg <= wr_data & `MASK_TX_INTERLEAVE_BUS_CTRL;
        end
        `IDX_TX_CHANNEL_MONITOR_SELECT: begin
          tx_channel_monitor_select_reg <= wr_data & `MASK_TX_CHANNEL_MONITOR_SELECT;
        end
        `IDX_TX_EXPANSION_PORT_CTRL: begin
          tx_expansion_port_ctrl_reg <= wr_data & `MASK_TX_EXPANSION_PORT_CTRL;
        end
        `IDX_TX_BERT_BIT_SUPPRESS: begin
          tx_bert_bit_suppress_reg <= wr_data & `MASK_TX_BERT_BIT_SUPPRESS;
        end
        // software clears and sets resync to re-arm
        `IDX_TX_SYNCHRONIZER_CTRL: begin
          tx_synchronizer_ctrl_reg <= wr_data & `MASK_TX_SYNCHRONIZER_CTRL;
        end
        default: tx_control_four_reg <= tx_control_four_reg;
      endcase
    end
  end

  // ********************
  // Channel monitor capture
  // ********************
  always @(posedge aclk) begin
    if (!aresetn) begin
      channel_monitor_reg <= `RST_CTRL_REG;
    end else begin
      // index 0 is channel 1, 31 is channel 32
      if (tx_channel_strobe &&
          tx_channel_index == tx_channel_monitor_select_reg[`POS_MONITOR_SEL_HI:`POS_MONITOR_SEL_LO]) begin
        channel_monitor_reg <= tx_channel_data;
      end
    end
  end

  assign monitor_channel_sel =
    tx_channel_monitor_select_reg[`POS_MONITOR_SEL_HI:`POS_MONITOR_SEL_LO];

  // ********************
  // Read channel
  // ********************
  reg [7:0] rd_value;
  reg rd_hit;
  wire [11:0] rd_index;
  wire rd_aligned;

  assign rd_index = s_axi_araddr[13:2];
  assign rd_aligned = (s_axi_araddr[1:0] == 2'b00);

  always @* begin
    rd_hit = rd_aligned;
    case (rd_index)
      `IDX_TX_CONTROL_FOUR: rd_value = tx_control_four_reg;
      `IDX_TX_HDLC_FIFO_CTRL: rd_value = tx_hdlc_fifo_ctrl_reg;
      `IDX_TX_INTERLEAVE_BUS_CTRL: rd_value = tx_interleave_bus_ctrl_reg;
      `IDX_TX_CHANNEL_MONITOR_SELECT: rd_value = tx_channel_monitor_select_reg;
      `IDX_TX_EXPANSION_PORT_CTRL: rd_value = tx_expansion_port_ctrl_reg;
      `IDX_TX_BERT_BIT_SUPPRESS: rd_value = tx_bert_bit_suppress_reg;
      `IDX_CHANNEL_MONITOR_REG: rd_value = channel_monitor_reg;
      `IDX_TX_SYNCHRONIZER_CTRL: rd_value = tx_synchronizer_ctrl_reg;
      default: begin
        rd_value = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, (rd_hit ? rd_value : 8'h00)};
      s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ********************
  // Field decode
  // ********************
  // Decode outputs are flops inside the decoder, one cycle after the write
  tx_ctrl_decode decode_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .control_four(tx_control_four_reg),
    .fifo_ctrl(tx_hdlc_fifo_ctrl_reg),
    .bus_ctrl(tx_interleave_bus_ctrl_reg),
    .port_ctrl(tx_expansion_port_ctrl_reg),
    .bit_suppress(tx_bert_bit_suppress_reg),
    .sync_ctrl(tx_synchronizer_ctrl_reg),
    .t1_mode(t1_mode),
    .esf_mode(esf_mode),
    .signaling_frame(signaling_frame),
    .remote_alarm_send(remote_alarm_send),
    .ais_send(ais_send),
    .loop_code_enable(loop_code_enable),
    .invert_framing(invert_framing),
    .invert_signaling(invert_signaling),
    .invert_payload(invert_payload),
    .jam_bit8_force(jam_bit8_force),
    .jam_bit7_force(jam_bit7_force),
    .send_rai_normal(send_rai_normal),
    .send_remote_alarm_ci_variant(send_remote_alarm_ci_variant),
    .send_ais_all_ones(send_ais_all_ones),
    .send_variant_a(send_variant_a),
    .loop_code_active(loop_code_active),
    .loop_code_bits(loop_code_bits),
    .hdlc_low_mark_bytes(hdlc_low_mark_bytes),
    .interleave_active(interleave_active),
    .interleave_frame_mode(interleave_frame_mode),
    .bert_to_tx_path(bert_to_tx_path),
    .bert_to_rx_serial_out(bert_to_rx_serial_out),
    .bert_in_framing_bit(bert_in_framing_bit),
    .bert_bit_use(bert_bit_use),
    .sync_active(sync_active),
    .crc_search_active(crc_search_active),
    .auto_resync_active(auto_resync_active),
    .resync_start(resync_start)
  );

endmodule // tx_ctrl_regs

`default_nettype wire

// >>> pkg/tx_ctrl_defs.vh
// Register indices, field positions, masks and reset values of the transmit control bank
`ifndef TX_CTRL_DEFS_VH
`define TX_CTRL_DEFS_VH

// ********************
// Register indices (byte address is four times the index)
// ********************
`define IDX_TX_CONTROL_FOUR 12'h186
`define IDX_TX_HDLC_FIFO_CTRL 12'h187
`define IDX_TX_INTERLEAVE_BUS_CTRL 12'h188
`define IDX_TX_CHANNEL_MONITOR_SELECT 12'h189
`define IDX_TX_EXPANSION_PORT_CTRL 12'h18a
`define IDX_TX_BERT_BIT_SUPPRESS 12'h18b
`define IDX_CHANNEL_MONITOR_REG 12'h18c
`define IDX_TX_SYNCHRONIZER_CTRL 12'h18e

// ********************
// Writable bit masks; other bits read as zero
// ********************
`define MASK_TX_CONTROL_FOUR 8'hff
`define MASK_TX_HDLC_FIFO_CTRL 8'h03
`define MASK_TX_INTERLEAVE_BUS_CTRL 8'h18
`define MASK_TX_CHANNEL_MONITOR_SELECT 8'h1f
`define MASK_TX_EXPANSION_PORT_CTRL 8'h07
`define MASK_TX_BERT_BIT_SUPPRESS 8'hff
`define MASK_TX_SYNCHRONIZER_CTRL 8'h0f

// ********************
// Reset values
// ********************
`define RST_CTRL_REG 8'h00

// ********************
// Field positions
// ********************
`define POS_INVERT_HI 6
`define POS_INVERT_LO 5
`define POS_JAM_BIT8_ENABLE 4
`define POS_REMOTE_ALARM_VARIANT_SEL 3
`define POS_AIS_VARIANT_SEL 2
`define POS_LOOP_LEN_HI 1
`define POS_LOOP_LEN_LO 0
`define POS_LOW_MARK_HI 1
`define POS_LOW_MARK_LO 0
`define POS_INTERLEAVE_KIND_SEL 4
`define POS_INTERLEAVE_ON 3
`define POS_MONITOR_SEL_HI 4
`define POS_MONITOR_SEL_LO 0
`define POS_BERT_PORT_DIRECTION 2
`define POS_BERT_FRAMING_SEL 1
`define POS_BERT_PORT_ON 0
`define POS_CRC_MULTIFRAME_SEARCH 3
`define POS_TX_SYNC_ON 2
`define POS_AUTO_RESYNC_DISABLE 1
`define POS_RESYNC 0

// ********************
// Field encodings
// ********************
`define INV_NONE 2'b00
`define INV_FRAMING 2'b01
`define INV_SIGNALING 2'b10
`define INV_PAYLOAD 2'b11
`define LOOP_LEN_5 2'b00
`define LOOP_LEN_6 2'b01
`define LOOP_LEN_7 2'b10
`define LOOP_LEN_16 2'b11
`define MARK_4 2'b00
`define MARK_16 2'b01
`define MARK_32 2'b10
`define MARK_48 2'b11
`define MARK_BYTES_4 6'h04
`define MARK_BYTES_16 6'h10
`define MARK_BYTES_32 6'h20
`define MARK_BYTES_48 6'h30
`define LOOP_BITS_5 5'h05
`define LOOP_BITS_6 5'h06
`define LOOP_BITS_7 5'h07
`define LOOP_BITS_16 5'h10

// ********************
// Bus answers
// ********************
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// >>> logic/tx_ctrl_decode.v
// Registered decode of the transmit control fields into datapath controls
`include "tx_ctrl_defs.vh"
`default_nettype none

module tx_ctrl_decode (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] control_four,
  input wire [7:0] fifo_ctrl,
  input wire [7:0] bus_ctrl,
  input wire [7:0] port_ctrl,
  input wire [7:0] bit_suppress,
  input wire [7:0] sync_ctrl,
  input wire t1_mode,
  input wire esf_mode,
  input wire signaling_frame,
  input wire remote_alarm_send,
  input wire ais_send,
  input wire loop_code_enable,
  output reg invert_framing,
  output reg invert_signaling,
  output reg invert_payload,
  output reg jam_bit8_force,
  output reg jam_bit7_force,
  output reg send_rai_normal,
  output reg send_remote_alarm_ci_variant,
  output reg send_ais_all_ones,
  output reg send_variant_a,
  output reg loop_code_active,
  output reg [4:0] loop_code_bits,
  output reg [5:0] hdlc_low_mark_bytes,
  output reg interleave_active,
  output reg interleave_frame_mode,
  output reg bert_to_tx_path,
  output reg bert_to_rx_serial_out,
  output reg bert_in_framing_bit,
  output reg [7:0] bert_bit_use,
  output reg sync_active,
  output reg crc_search_active,
  output reg auto_resync_active,
  output reg resync_start
);

  wire [1:0] inv_sel;
  wire [1:0] len_sel;
  wire [1:0] mark_sel;
  wire bert_on;
  wire sync_on;
  reg resync_seen_reg;
  reg [4:0] loop_bits_next;
  reg [5:0] mark_next;

  assign inv_sel = control_four[`POS_INVERT_HI:`POS_INVERT_LO];
  assign len_sel = control_four[`POS_LOOP_LEN_HI:`POS_LOOP_LEN_LO];
  assign mark_sel = fifo_ctrl[`POS_LOW_MARK_HI:`POS_LOW_MARK_LO];
  assign bert_on = port_ctrl[`POS_BERT_PORT_ON];
  assign sync_on = sync_ctrl[`POS_TX_SYNC_ON];

  always @* begin
    case (len_sel)
      `LOOP_LEN_5: loop_bits_next = `LOOP_BITS_5;
      `LOOP_LEN_6: loop_bits_next = `LOOP_BITS_6;
      `LOOP_LEN_7: loop_bits_next = `LOOP_BITS_7;
      default: loop_bits_next = `LOOP_BITS_16;
    endcase
    case (mark_sel)
      `MARK_4: mark_next = `MARK_BYTES_4;
      `MARK_16: mark_next = `MARK_BYTES_16;
      `MARK_32: mark_next = `MARK_BYTES_32;
      default: mark_next = `MARK_BYTES_48;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      invert_framing <= 1'b0;
      invert_signaling <= 1'b0;
      invert_payload <= 1'b0;
      jam_bit8_force <= 1'b0;
      jam_bit7_force <= 1'b0;
      send_rai_normal <= 1'b0;
      send_remote_alarm_ci_variant <= 1'b0;
      send_ais_all_ones <= 1'b0;
      send_variant_a <= 1'b0;
      loop_code_active <= 1'b0;
      loop_code_bits <= `LOOP_BITS_5;
      hdlc_low_mark_bytes <= `MARK_BYTES_4;
      interleave_active <= 1'b0;
      interleave_frame_mode <= 1'b0;
      bert_to_tx_path <= 1'b0;
      bert_to_rx_serial_out <= 1'b0;
      bert_in_framing_bit <= 1'b0;
      bert_bit_use <= 8'h00;
      sync_active <= 1'b0;
      crc_search_active <= 1'b0;
      auto_resync_active <= 1'b0;
      resync_start <= 1'b0;
      resync_seen_reg <= 1'b0;
    end else begin
      invert_framing <= (inv_sel == `INV_FRAMING);
      invert_signaling <= (inv_sel == `INV_SIGNALING);
      invert_payload <= (inv_sel == `INV_PAYLOAD);
      // jam bit 8, bit 7 in signaling frames
      jam_bit8_force <= control_four[`POS_JAM_BIT8_ENABLE];
      jam_bit7_force <= control_four[`POS_JAM_BIT8_ENABLE] & t1_mode & signaling_frame;
      send_remote_alarm_ci_variant <= t1_mode & esf_mode & remote_alarm_send &
                     control_four[`POS_REMOTE_ALARM_VARIANT_SEL];
      send_rai_normal <= remote_alarm_send &
                         ~(t1_mode & esf_mode & control_four[`POS_REMOTE_ALARM_VARIANT_SEL]);
      send_ais_all_ones <= ais_send & ~(t1_mode & control_four[`POS_AIS_VARIANT_SEL]);
      send_variant_a <= ais_send & t1_mode & control_four[`POS_AIS_VARIANT_SEL];
      // loop code replaces data in T1
      loop_code_active <= loop_code_enable & t1_mode;
      loop_code_bits <= loop_bits_next;
      hdlc_low_mark_bytes <= mark_next;
      interleave_active <= bus_ctrl[`POS_INTERLEAVE_ON];
      interleave_frame_mode <= bus_ctrl[`POS_INTERLEAVE_KIND_SEL];
      bert_to_tx_path <= bert_on & ~port_ctrl[`POS_BERT_PORT_DIRECTION];
      bert_to_rx_serial_out <= bert_on & port_ctrl[`POS_BERT_PORT_DIRECTION];
      bert_in_framing_bit <= bert_on & port_ctrl[`POS_BERT_FRAMING_SEL];
      bert_bit_use <= bert_on ? ~bit_suppress : 8'h00;
      sync_active <= sync_on;
      crc_search_active <= sync_on & ~t1_mode & sync_ctrl[`POS_CRC_MULTIFRAME_SEARCH];
      // auto resync when bit is 0
      auto_resync_active <= sync_on & ~sync_ctrl[`POS_AUTO_RESYNC_DISABLE];
      // one pulse per rising edge of the bit
      resync_seen_reg <= sync_ctrl[`POS_RESYNC];
      resync_start <= sync_ctrl[`POS_RESYNC] & ~resync_seen_reg;
    end
  end

endmodule // tx_ctrl_decode

`default_nettype wire

// >>> verif/tx_ctrl_regs_chk.sv
// Concurrent checks on the transmit control register bank ports
`default_nettype none

module tx_ctrl_regs_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic t1_mode,
  input wire logic esf_mode,
  input wire logic signaling_frame,
  input wire logic remote_alarm_send,
  input wire logic ais_send,
  input wire logic loop_code_enable,
  input wire logic invert_framing,
  input wire logic invert_signaling,
  input wire logic invert_payload,
  input wire logic jam_bit8_force,
  input wire logic jam_bit7_force,
  input wire logic send_remote_alarm_ci_variant,
  input wire logic send_variant_a,
  input wire logic loop_code_active,
  input wire logic [4:0] loop_code_bits,
  input wire logic [5:0] hdlc_low_mark_bytes,
  input wire logic bert_to_tx_path,
  input wire logic bert_to_rx_serial_out,
  input wire logic bert_in_framing_bit,
  input wire logic [7:0] bert_bit_use,
  input wire logic sync_active,
  input wire logic crc_search_active,
  input wire logic auto_resync_active,
  input wire logic resync_start
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ********************
  // Assertions
  // ********************
  chk_inv_onehot: assert property (
    $onehot0({invert_framing, invert_signaling, invert_payload})) else $error("inversion");
  chk_jam_bit7: assert property (
    jam_bit7_force |-> jam_bit8_force && $past(t1_mode && signaling_frame))
    else $error("bit 7 jam");
  chk_rai_variant: assert property (
    send_remote_alarm_ci_variant |-> $past(t1_mode && esf_mode && remote_alarm_send)) else $error("remote_alarm_ci_variant");
  chk_ais_variant: assert property (
    send_variant_a |-> $past(t1_mode && ais_send)) else $error("variant_a");
  chk_loop_len: assert property (
    loop_code_bits inside {5'h05, 5'h06, 5'h07, 5'h10}) else $error("loop length");
  chk_low_mark: assert property (
    hdlc_low_mark_bytes inside {6'h04, 6'h10, 6'h20, 6'h30}) else $error("low mark");
  chk_bert_dir: assert property (
    !(bert_to_tx_path && bert_to_rx_serial_out)) else $error("bert both ways");
  chk_bert_off: assert property (
    !(bert_to_tx_path || bert_to_rx_serial_out) |-> bert_bit_use == 8'h00 && !bert_in_framing_bit)
    else $error("bert idle");
  chk_crc_search: assert property (
    crc_search_active |-> sync_active && !$past(t1_mode)) else $error("crc search");
  chk_auto_resync: assert property (
    auto_resync_active |-> sync_active) else $error("auto resync");
  chk_resync_once: assert property (
    resync_start |=> !resync_start) else $error("resync pulse");
  chk_loop_t1: assert property (
    loop_code_active |-> $past(loop_code_enable && t1_mode)) else $error("loop code");
  chk_reset_idle: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !sync_active && loop_code_bits == 5'h05)
    else $error("reset state");
  cov_remote_alarm_ci_variant: cover property (send_remote_alarm_ci_variant);
  cov_resync: cover property (resync_start);
  cov_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule // tx_ctrl_regs_chk

bind tx_ctrl_regs tx_ctrl_regs_chk tx_ctrl_regs_chk_i (.*);
`default_nettype wire

// >>> verif/tx_framer_control_regs_bench.sv
// Self-checking bench for the transmit control register bank
`default_nettype none

module tx_framer_control_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, t1_mode = 0, esf_mode = 0, signaling_frame = 0;
  logic remote_alarm_send = 0, ais_send = 0, loop_code_enable = 0, tx_channel_strobe = 0;
  logic [13:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'hc8bfa78c;
  logic [3:0] s_axi_wstrb = 0;
  logic [7:0] tx_channel_data = 0, bert_bit_use, pulses = 0, m [9];
  logic [4:0] tx_channel_index = 0, loop_code_bits, monitor_channel_sel;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [5:0] hdlc_low_mark_bytes;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic invert_framing, invert_signaling, invert_payload, jam_bit8_force, jam_bit7_force;
  logic send_rai_normal, send_remote_alarm_ci_variant, send_ais_all_ones, send_variant_a, loop_code_active;
  logic interleave_active, interleave_frame_mode, bert_to_tx_path, bert_to_rx_serial_out;
  logic bert_in_framing_bit, sync_active, crc_search_active, auto_resync_active, resync_start;
  int err_total = 0, checks_done = 0;
  localparam logic [7:0] MSK [9] = '{8'hff, 8'h03, 8'h18, 8'h1f, 8'h07, 8'hff, 0, 0, 8'h0f};
  localparam logic [4:0] LENS [4] = '{5'h05, 5'h06, 5'h07, 5'h10};
  localparam logic [5:0] MARKS [4] = '{6'h04, 6'h10, 6'h20, 6'h30};

  tx_ctrl_regs tx_ctrl_regs_i (.*);

  always #2 aclk = ~aclk;
  always @(posedge aclk) if (resync_start === 1'b1) pulses <= pulses + 8'h01;
  // Far more than the sequence needs; a hang ends here
  initial begin
    repeat (8000) @(posedge aclk);
    err_total++;
    finish_test;
  end

  // ********************
  // Compare tasks
  // ********************
  task automatic cmp_bus(input logic [33:0] g, input logic [33:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t bus got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_dec(input logic [48:0] g, input logic [48:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t decode got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_cnt(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t pulse count got %0d exp %0d", $time, g, e);
    end
  endtask

  // ********************
  // Bus master and model
  // ********************
  task automatic rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
  endtask
  task automatic wr(input int k, input logic [7:0] d, input logic [3:0] st);
    logic a, w, ra, rw, bad;
    a = 0;
    w = 0;
    bad = (k == 6 || k == 7);
    s_axi_awaddr <= 14'((390 + k) * 4);
    s_axi_wdata <= {seed[23:0], d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(a && w)) begin
      @(negedge aclk);
      ra = (s_axi_awready === 1'b1);
      rw = (s_axi_wready === 1'b1);
      @(posedge aclk);
      if (!a && ra) begin
        a = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && rw) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    cmp_bus({s_axi_bresp, 32'h0}, {bad ? 2'b10 : 2'b00, 32'h0});
    @(posedge aclk);
    if (!bad && st[0]) m[k] = d & MSK[k];
  endtask
  task automatic rd(input int k);
    logic ra;
    ra = 0;
    s_axi_araddr <= 14'((390 + k) * 4);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!ra) begin
      @(negedge aclk);
      ra = (s_axi_arready === 1'b1);
      @(posedge aclk);
    end
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    cmp_bus({s_axi_rresp, s_axi_rdata}, {k == 7 ? 2'b10 : 2'b00, 24'h0, m[k]});
    @(posedge aclk);
  endtask
  task automatic chk_dec;
    logic [7:0] c, x, s;
    logic q;
    c = m[0];
    x = m[4];
    s = m[8];
    q = t1_mode & esf_mode & c[3];
    @(negedge aclk);
    cmp_dec({invert_framing, invert_signaling, invert_payload, jam_bit8_force, jam_bit7_force,
      send_rai_normal, send_remote_alarm_ci_variant, send_ais_all_ones, send_variant_a, loop_code_active,
      loop_code_bits, hdlc_low_mark_bytes, interleave_active, interleave_frame_mode,
      monitor_channel_sel, bert_to_tx_path, bert_to_rx_serial_out, bert_in_framing_bit,
      bert_bit_use, sync_active, crc_search_active, auto_resync_active},
      {c[6:5] == 2'b01, c[6:5] == 2'b10, c[6:5] == 2'b11, c[4], c[4] & t1_mode & signaling_frame,
      remote_alarm_send & ~q, remote_alarm_send & q, ais_send & ~(t1_mode & c[2]),
      ais_send & t1_mode & c[2], loop_code_enable & t1_mode, LENS[c[1:0]], MARKS[m[1][1:0]],
      m[2][3], m[2][4], m[3][4:0], x[0] & ~x[2], x[0] & x[2], x[0] & x[1],
      x[0] ? ~m[5] : 8'h00, s[2], s[2] & ~t1_mode & s[3], s[2] & ~s[1]});
    @(posedge aclk);
  endtask
  task automatic rst;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (m[i]) m[i] = 8'h00;
  endtask

  // ********************
  // Main sequence
  // ********************
  initial begin
    rst;
    for (int k = 0; k < 9; k++) rd(k);
    for (int k = 0; k < 4; k++) begin
      wr(0, {1'b0, 2'(k), 3'b000, 2'(k)}, 4'h1);
      wr(1, 8'(k), 4'h1);
      chk_dec;
    end
    for (int r = 0; r < 40; r++) begin
      int k;
      rnd;
      {t1_mode, esf_mode, signaling_frame} <= seed[5:3];
      {remote_alarm_send, ais_send, loop_code_enable} <= seed[2:0];
      k = seed[10:8] % 7;
      if (k == 6) k = 8;
      wr(k, seed[31:24], 4'h1);
      rd(k);
      chk_dec;
    end
    wr(1, 8'hff, 4'h0);
    rd(1);
    wr(7, 8'hff, 4'h1);
    rd(7);
    wr(6, 8'h55, 4'h1);
    // Channel 32 boundary, then a non-matching channel that must not land
    wr(3, 8'h1f, 4'h1);
    tx_channel_index <= 5'h1f;
    tx_channel_data <= 8'ha5;
    tx_channel_strobe <= 1'b1;
    @(posedge aclk);
    tx_channel_index <= 5'h00;
    tx_channel_data <= 8'h3c;
    @(posedge aclk);
    tx_channel_strobe <= 1'b0;
    m[6] = 8'ha5;
    rd(6);
    wr(8, 8'h00, 4'h1);
    for (int i = 0; i < 4; i++) begin
      logic [7:0] p;
      p = pulses;
      if (i == 2) wr(8, 8'h04, 4'h1);
      wr(8, 8'h05, 4'h1);
      repeat (4) @(posedge aclk);
      cmp_cnt(pulses - p, 8'(1 - i % 2));
    end
    rst;
    for (int k = 0; k < 9; k++) rd(k);
    chk_dec;
    finish_test;
  end

  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
endmodule // tx_framer_control_regs_bench
`default_nettype wire
